/* File: src/dui_irq_logic.sv */
// Channel A interrupt logic of a dual asynchronous serial controller: status,
// write-only mask, masked status, vector register, servicing modes and the
// channel A receive FIFO and transmit holding register that feed the status.
// Assumes a 32-bit APB master on pclk and a serializer/deserializer outside.
//
// Our own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none

module dui_irq_logic #(
  parameter int unsigned RX_DEPTH = dui_pkg::RX_DEPTH_DEF
) (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [dui_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  input  wire logic [3:0]                 pstrb,
  output logic                            pready,
  output logic [31:0]                     prdata,
  output logic                            pslverr,
  input  wire dui_pkg::dui_char_t         rx_shift_reg,
  input  wire logic                       tx_shift_empty,
  output dui_pkg::dui_char_t              tx_shift_reg,
  input  wire logic [5:0]                 other_status,
  output logic                            irq_out_n,
  input  wire logic                       irq_ack,
  input  wire logic                       prio_in,
  output logic                            prio_out,
  output logic [7:0]                      vec_data,
  output logic                            vec_oe
);

  // Pointers are two bits and the count three, which bounds the depth;
  // the check runs at elaboration so a bad depth never reaches simulation
  if (RX_DEPTH < 2) begin : g_depth_lo
    $error("RX_DEPTH must be at least 2");
  end
  if (RX_DEPTH > 4) begin : g_depth_hi
    $error("RX_DEPTH must not exceed 4");
  end

  localparam logic [dui_pkg::CNT_W-1:0] DEPTH_C = dui_pkg::CNT_W'(RX_DEPTH);
  localparam logic [dui_pkg::PTR_W-1:0] LAST_C  = dui_pkg::PTR_W'(RX_DEPTH - 1);

  dui_pkg::dui_state_t s_r;
  dui_pkg::dui_state_t s_nxt;
  logic [7:0]          fifo_mem [RX_DEPTH];

  logic [dui_pkg::IDX_W-1:0] idx;
  logic                      mapped;
  logic                      acc_wr;
  logic                      acc_rd;
  logic                      pop;
  logic                      push;
  logic                      take;
  logic [7:0]                irq_status;
  logic [7:0]                masked_irq_status;
  logic [7:0]                stat_a;
  logic [dui_pkg::CNT_W-1:0] cnt_after;

  logic                      sel_mode1;
  logic                      sel_stat;
  logic                      sel_masked_irq_status;
  logic                      sel_data;
  logic                      sel_isr_imr;
  logic                      sel_vector;
  logic                      sel_cmd;
  logic                      rd_setup;
  logic [31:0]               rd_word;
  logic                      rx_set;
  logic                      rx_clr;
  logic [dui_pkg::PTR_W-1:0] wr_ptr_inc;
  logic [dui_pkg::PTR_W-1:0] rd_ptr_inc;

  assign idx = paddr[dui_pkg::ADDR_W-1:2];

  // One select per register keeps the error decode and the read mux in step
  assign sel_mode1   = (idx == dui_pkg::IDX_MODE1_A);
  assign sel_stat    = (idx == dui_pkg::IDX_STAT_A);
  assign sel_masked_irq_status    = (idx == dui_pkg::IDX_MASKED_IRQ_STATUS);
  assign sel_data    = (idx == dui_pkg::IDX_DATA_A);
  assign sel_isr_imr = (idx == dui_pkg::IDX_ISR_IMR);
  assign sel_vector  = (idx == dui_pkg::IDX_VECTOR);
  assign sel_cmd     = (idx == dui_pkg::IDX_CMD);
  assign mapped      = sel_mode1 || sel_stat || sel_masked_irq_status || sel_data ||
                       sel_isr_imr || sel_vector || sel_cmd;

  assign acc_wr   = psel && penable && pwrite && mapped && pstrb[0];
  assign acc_rd   = psel && penable && !pwrite && mapped;
  assign rd_setup = psel && !penable && !pwrite;

  // Reading the data register pops the FIFO only when something is there
  assign pop  = acc_rd && (idx == dui_pkg::IDX_DATA_A) && (s_r.cnt != '0);
  // A waiting character loads only once there is room; after a pop it
  // therefore lands one cycle later, which re-raises the full flag
  assign push = s_r.rsr_wait && (s_r.cnt != DEPTH_C);
  // Handoff into the shift register needs an enabled transmitter
  assign take = s_r.tx_en && s_r.thr_full && tx_shift_empty;

  assign cnt_after = s_r.cnt + dui_pkg::CNT_W'(push) - dui_pkg::CNT_W'(pop);

  assign wr_ptr_inc = (s_r.wr_ptr == LAST_C) ? '0 : s_r.wr_ptr + 1'b1;
  assign rd_ptr_inc = (s_r.rd_ptr == LAST_C) ? '0 : s_r.rd_ptr + 1'b1;

  // A transfer wins over a same-cycle pop, so a fresh arrival is not hidden
  assign rx_set = push &&
                  (!s_r.rx_sel_full || (cnt_after == DEPTH_C));
  assign rx_clr = pop;

  // Status bits follow their causes whatever the mask holds
  always_comb begin
    irq_status = 8'h00;
    irq_status[dui_pkg::ISR_TX_READY]     = s_r.tx_flag;
    irq_status[dui_pkg::ISR_RX_FLAG]      = s_r.rx_flag;
    irq_status[7:dui_pkg::ISR_OTHER_LO]   = other_status;
  end

  assign masked_irq_status = irq_status & s_r.mask;

  always_comb begin
    stat_a = 8'h00;
    stat_a[dui_pkg::STAT_RX_READY] = (s_r.cnt != '0);
    stat_a[dui_pkg::STAT_RX_FULL]  = (s_r.cnt == DEPTH_C);
    stat_a[dui_pkg::STAT_TX_READY] = s_r.tx_flag;
    stat_a[dui_pkg::STAT_TX_EMPTY] = s_r.tx_en && !s_r.thr_full;
    stat_a[dui_pkg::STAT_OVERRUN]  = s_r.overrun;
  end

  // Read word of the addressed register; the mask address reads as status
  always_comb begin
    rd_word = 32'h0000_0000;
    case (idx)
      dui_pkg::IDX_MODE1_A: rd_word[dui_pkg::MR1_RX_SEL_BIT] = s_r.rx_sel_full;
      dui_pkg::IDX_STAT_A:  rd_word[7:0] = stat_a;
      dui_pkg::IDX_MASKED_IRQ_STATUS:    rd_word[7:0] = masked_irq_status;
      dui_pkg::IDX_DATA_A:  rd_word[7:0] = fifo_mem[s_r.rd_ptr];
      dui_pkg::IDX_ISR_IMR: rd_word[7:0] = irq_status;
      dui_pkg::IDX_VECTOR:  rd_word[7:0] = s_r.vector;
      default: begin
      end
    endcase
  end

  always_comb begin
    s_nxt         = s_r;
    s_nxt.tx_load = 1'b0;

    // Read data is captured in the setup cycle so prdata comes from a flop
    // The value may be one cycle stale against the access edge
    if (rd_setup) begin
      s_nxt.prdata = rd_word;
    end

    // Transmit holding register hands off to the shift register
    if (take) begin
      s_nxt.tx_load  = 1'b1;
      s_nxt.tx_data  = s_r.thr_data;
      s_nxt.thr_full = 1'b0;
    end

    if (acc_wr) begin
      case (idx)
        dui_pkg::IDX_MODE1_A: begin
          s_nxt.rx_sel_full = pwdata[dui_pkg::MR1_RX_SEL_BIT];
        end
        dui_pkg::IDX_ISR_IMR: begin
          s_nxt.mask = pwdata[7:0];
        end
        dui_pkg::IDX_VECTOR: begin
          s_nxt.vector = pwdata[7:0];
        end
        dui_pkg::IDX_DATA_A: begin
          // Characters offered to a disabled transmitter are dropped here
          if (s_r.tx_en) begin
            s_nxt.thr_data = pwdata[7:0];
            s_nxt.thr_full = 1'b1;
          end
        end
        dui_pkg::IDX_CMD: begin
          case (pwdata[3:0])
            dui_pkg::CMD_TX_ENABLE: begin
              s_nxt.tx_en = 1'b1;
            end
            dui_pkg::CMD_TX_DISABLE: begin
              s_nxt.tx_en    = 1'b0;
              s_nxt.thr_full = 1'b0;
            end
            dui_pkg::CMD_SET_VECTOR: begin
              s_nxt.mode = dui_pkg::DUI_MODE_VEC;
            end
            dui_pkg::CMD_CLR_OVERRUN: begin
              s_nxt.overrun = 1'b0;
            end
            default: begin
            end
          endcase
        end
        default: begin
        end
      endcase
    end

    // Transmit ready mirrors an enabled, empty holding register
    s_nxt.tx_flag = s_nxt.tx_en && !s_nxt.thr_full;

    // Receive side: one character may wait behind a full FIFO; a second
    // arrival replaces it and is flagged as overrun
    if (rx_shift_reg.valid) begin
      if (s_r.rsr_wait && !push) begin
        s_nxt.overrun = 1'b1;
      end
      s_nxt.rsr_wait = 1'b1;
      s_nxt.rsr_data = rx_shift_reg.data;
    end else if (push) begin
      s_nxt.rsr_wait = 1'b0;
    end
    if (push) begin
      s_nxt.wr_ptr = wr_ptr_inc;
    end
    if (pop) begin
      s_nxt.rd_ptr = rd_ptr_inc;
    end
    s_nxt.cnt = cnt_after;

    // Receive flag: a transfer wins over a same-cycle pop
    if (rx_set) begin
      s_nxt.rx_flag = 1'b1;
    end else if (rx_clr) begin
      s_nxt.rx_flag = 1'b0;
    end else if (!s_r.rx_sel_full) begin
      s_nxt.rx_flag = (s_r.cnt != '0);
    end else begin
      // A partly filled FIFO never raises the full flag
      s_nxt.rx_flag = s_r.rx_flag && (s_r.cnt == DEPTH_C);
    end

    // Request output, low while any enabled cause stands
    s_nxt.irq_n = ~|masked_irq_status;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r             <= '0;
      s_r.mask        <= dui_pkg::MASK_RST;
      s_r.vector      <= dui_pkg::VECTOR_RST;
      s_r.mode        <= dui_pkg::DUI_MODE_NOVEC;
      s_r.irq_n       <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Character storage; written from the waiting character on a push
  always_ff @(posedge pclk) begin
    if (push) begin
      fifo_mem[s_r.wr_ptr] <= s_r.rsr_data;
    end
  end

  // Zero-wait slave: the access phase always completes at once
  assign pready  = penable;
  assign pslverr = psel && penable && !mapped;
  assign prdata  = s_r.prdata;

  assign tx_shift_reg.valid = s_r.tx_load;
  assign tx_shift_reg.data  = s_r.tx_data;
  assign irq_out_n          = s_r.irq_n;
  assign vec_data           = s_r.vector;

  // Only the highest-priority requester in the chain answers the
  // acknowledge; a device without a request passes the grant on
  assign vec_oe   = irq_ack && (s_r.mode == dui_pkg::DUI_MODE_VEC) &&
                    prio_in && !s_r.irq_n;
  assign prio_out = prio_in &&
                    ((s_r.mode != dui_pkg::DUI_MODE_VEC) || s_r.irq_n);

endmodule

`default_nettype wire

/* File: src/dui_pkg.sv */
// Package of the channel A interrupt logic: register indices, field positions,
// reset values, commands, the servicing-mode enum and the state carriers.
// Assumes a 32-bit APB with word-aligned registers; byte address = index * 4.
package dui_pkg;

  // Register indices; the bus address is the index shifted left by two
  localparam int unsigned       IDX_W        = 4;
  localparam int unsigned       ADDR_W       = IDX_W + 2;
  localparam logic [IDX_W-1:0]  IDX_MODE1_A  = 4'h0;
  localparam logic [IDX_W-1:0]  IDX_STAT_A   = 4'h1;
  localparam logic [IDX_W-1:0]  IDX_MASKED_IRQ_STATUS     = 4'h2;
  localparam logic [IDX_W-1:0]  IDX_DATA_A   = 4'h3;
  localparam logic [IDX_W-1:0]  IDX_ISR_IMR  = 4'h5;
  localparam logic [IDX_W-1:0]  IDX_VECTOR   = 4'hc;
  localparam logic [IDX_W-1:0]  IDX_CMD      = 4'hd;

  // Field positions
  localparam int unsigned MR1_RX_SEL_BIT  = 6;
  localparam int unsigned ISR_TX_READY    = 0;
  localparam int unsigned ISR_RX_FLAG     = 1;
  localparam int unsigned ISR_OTHER_LO    = 2;
  localparam int unsigned STAT_RX_READY   = 0;
  localparam int unsigned STAT_RX_FULL    = 1;
  localparam int unsigned STAT_TX_READY   = 2;
  localparam int unsigned STAT_TX_EMPTY   = 3;
  localparam int unsigned STAT_OVERRUN    = 4;

  // Reset values
  localparam logic [7:0] MASK_RST   = 8'h00;
  localparam logic [7:0] VECTOR_RST = 8'h0f;

  // Command codes, written to the low nibble of the command register
  localparam logic [3:0] CMD_TX_ENABLE  = 4'h1;
  localparam logic [3:0] CMD_TX_DISABLE = 4'h2;
  localparam logic [3:0] CMD_SET_VECTOR = 4'h3;
  localparam logic [3:0] CMD_CLR_OVERRUN = 4'h4;

  localparam int unsigned RX_DEPTH_DEF = 3;
  localparam int unsigned CNT_W        = 3;
  localparam int unsigned PTR_W        = 2;

  typedef enum logic [1:0] {
    DUI_MODE_NOVEC = 2'b01,
    DUI_MODE_VEC   = 2'b10
  } dui_mode_t;

  // One character from the receive shift register or to the transmit shift register
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } dui_char_t;

  typedef struct packed {
    logic [7:0]       mask;
    logic [7:0]       vector;
    dui_mode_t        mode;
    logic             rx_sel_full;
    logic             tx_en;
    logic             thr_full;
    logic [7:0]       thr_data;
    logic             tx_flag;
    logic             rx_flag;
    logic [CNT_W-1:0] cnt;
    logic [PTR_W-1:0] rd_ptr;
    logic [PTR_W-1:0] wr_ptr;
    logic             rsr_wait;
    logic [7:0]       rsr_data;
    logic             overrun;
    logic             tx_load;
    logic [7:0]       tx_data;
    logic             irq_n;
    logic [31:0]      prdata;
  } dui_state_t;

endpackage

/* File: testbench/dui_irq_chk.sv */
// Port-level checker for the channel A interrupt logic.
// Assumes writes land at the APB access edge and reads answer with zero waits.
`timescale 1ns/1ps
`default_nettype none
module dui_irq_chk #(
  parameter int unsigned RX_DEPTH = 3
) (
  input wire logic                       pclk,
  input wire logic                       presetn,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [dui_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0]                pwdata,
  input wire logic [3:0]                 pstrb,
  input wire logic [31:0]                prdata,
  input wire logic                       irq_out_n,
  input wire logic                       irq_ack,
  input wire logic                       prio_in,
  input wire logic                       prio_out,
  input wire logic                       vec_oe,
  input wire dui_pkg::dui_char_t         tx_shift_reg
);
  logic [7:0] mask_r;
  logic       vec_r;
  logic       txen_r;
  logic [3:0] idx;
  logic       wr;
  logic       rd_masked_irq_status;
  assign idx = paddr[5:2];
  assign wr = psel && penable && pwrite && pstrb[0];
  assign rd_masked_irq_status = psel && penable && !pwrite && idx == dui_pkg::IDX_MASKED_IRQ_STATUS;
  // Shadow of the write-only mask and the mode, since software cannot read them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_r <= 8'h00;
      vec_r <= 1'b0;
      txen_r <= 1'b0;
    end else if (wr && idx == dui_pkg::IDX_ISR_IMR) begin
      mask_r <= pwdata[7:0];
    end else if (wr && idx == dui_pkg::IDX_CMD) begin
      vec_r <= vec_r | (pwdata[3:0] == dui_pkg::CMD_SET_VECTOR);
      txen_r <= (txen_r | (pwdata[3:0] == dui_pkg::CMD_TX_ENABLE))
                & (pwdata[3:0] != dui_pkg::CMD_TX_DISABLE);
    end
  end
  default clocking dui_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  AST_NOVEC_QUIET: assert property (!vec_r |-> !vec_oe)
    else $error("vector driven outside vector mode");
  AST_PRIO_PASS: assert property (!vec_r |-> prio_out == prio_in)
    else $error("priority chain broken in non-vector mode");
  AST_PRIO_BLOCK: assert property (vec_r && !irq_out_n |-> !prio_out)
    else $error("priority passed on while requesting");
  AST_VEC_DRIVE: assert property (vec_r && irq_ack && prio_in && !irq_out_n |-> vec_oe)
    else $error("no vector during acknowledge");
  AST_NO_MASK: assert property (mask_r == 8'h00 |=> irq_out_n)
    else $error("request with empty mask");
  AST_MASKED_IRQ_STATUS_AND: assert property (rd_masked_irq_status |-> (prdata[7:0] & ~mask_r) == 8'h00)
    else $error("masked status shows a disabled bit");
  AST_MASKED_IRQ_STATUS_IRQ: assert property (rd_masked_irq_status |-> (prdata[7:0] != 8'h00) == !irq_out_n)
    else $error("request output disagrees with masked status");
  AST_TX_DROP: assert property (!txen_r |=> !tx_shift_reg.valid)
    else $error("character sent while transmitter disabled");
  cover property (vec_oe);
  cover property (rd_masked_irq_status && !irq_out_n);
  cover property (tx_shift_reg.valid);
endmodule
bind dui_irq_logic dui_irq_chk #(.RX_DEPTH(RX_DEPTH)) u_dui_irq_chk (.*);
`default_nettype wire

/* File: testbench/dui_host_model.sv */
// Host processor side: acknowledges a pending request after ACK_DLY+1 cycles.
// The bench opens ack_en in both servicing modes, including direct interrupts where no vector is expected.
`timescale 1ns/1ps
`default_nettype none
module dui_host_model #(
  parameter logic [3:0] ACK_DLY = 4'h2
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic irq_out_n,
  input  wire logic ack_en,
  output logic      irq_ack
);
  logic [3:0] wait_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_r <= 4'h0;
      irq_ack <= 1'b0;
    end else if (!ack_en || irq_out_n) begin
      wait_r <= 4'h0;
      irq_ack <= 1'b0;
    end else if (wait_r == ACK_DLY) begin
      irq_ack <= 1'b1;
    end else begin
      wait_r <= wait_r + 4'h1;
    end
  end
endmodule
`default_nettype wire

/* File: testbench/dual_uart_interrupt_logic_tb_top.sv */
// Self-checking bench: APB register traffic, serial-side stimulus, host acks.
// Assumes the default receive FIFO depth of three.
`timescale 1ns/1ps
`default_nettype none
module dual_uart_interrupt_logic_tb_top;
  logic                       pclk = 1'b0;
  logic                       presetn = 1'b0;
  logic                       psel = 1'b0;
  logic                       penable = 1'b0;
  logic                       pwrite = 1'b0;
  logic                       tx_empty = 1'b0;
  logic                       prio_in = 1'b1;
  logic                       ack_en = 1'b0;
  logic                       pready, pslverr, irq_out_n, prio_out, vec_oe, irq_ack, rd_err;
  logic [dui_pkg::ADDR_W-1:0] paddr = '0;
  logic [31:0]                pwdata = '0;
  logic [31:0]                prdata, rd_d;
  logic [7:0]                 vec_data, tx_last;
  logic [7:0]                 tx_cnt = 8'h00;
  dui_pkg::dui_char_t         rxc = '0;
  dui_pkg::dui_char_t         txo;
  int                         err_total = 0;
  int                         n_compared = 0;
  int                         i;
  always #10 pclk = ~pclk;
  dui_irq_logic u_dui_irq_logic (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .rx_shift_reg(rxc),
    .tx_shift_empty(tx_empty), .tx_shift_reg(txo), .other_status(6'h2a),
    .irq_out_n(irq_out_n), .irq_ack(irq_ack), .prio_in(prio_in), .prio_out(prio_out),
    .vec_data(vec_data), .vec_oe(vec_oe));
  dui_host_model u_dui_host_model (.pclk(pclk), .presetn(presetn), .irq_out_n(irq_out_n),
    .ack_en(ack_en), .irq_ack(irq_ack));
  always @(posedge pclk) begin
    if (txo.valid === 1'b1) begin
      tx_cnt <= tx_cnt + 8'h01;
      tx_last <= txo.data;
    end
  end
  task automatic apb(input logic w, input logic [3:0] idx, input logic [7:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) err_total++;
    rd_d = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: expected %h got %h", $time, exp, got);
    end
  endtask
  task automatic rchk(input logic [3:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(exp, rd_d);
  endtask
  task automatic rx(input logic [7:0] d);
    @(posedge pclk);
    rxc <= '{valid: 1'b1, data: d};
    @(posedge pclk);
    rxc <= '0;
    repeat (3) @(posedge pclk);
  endtask
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    err_total++;
    test_done();
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rchk(dui_pkg::IDX_VECTOR, 32'h0f);
    apb(1'b1, dui_pkg::IDX_VECTOR, 8'h5a);
    rchk(dui_pkg::IDX_VECTOR, 32'h5a);
    rchk(dui_pkg::IDX_ISR_IMR, 32'ha8);
    rchk(dui_pkg::IDX_MASKED_IRQ_STATUS, 32'h00);
    apb(1'b1, dui_pkg::IDX_CMD, 8'h01);
    rchk(dui_pkg::IDX_STAT_A, 32'h0c);
    rchk(dui_pkg::IDX_ISR_IMR, 32'ha9);
    apb(1'b1, dui_pkg::IDX_ISR_IMR, 8'hff);
    rchk(dui_pkg::IDX_MASKED_IRQ_STATUS, 32'ha9);
    rchk(dui_pkg::IDX_ISR_IMR, 32'ha9);
    apb(1'b1, dui_pkg::IDX_ISR_IMR, 8'h02);
    rchk(dui_pkg::IDX_MASKED_IRQ_STATUS, 32'h00);
    chk(32'h1, {31'h0, irq_out_n});
    apb(1'b1, dui_pkg::IDX_DATA_A, 8'h3c);
    rchk(dui_pkg::IDX_ISR_IMR, 32'ha8);
    tx_empty <= 1'b1;
    repeat (4) @(posedge pclk);
    chk(32'h013c, {16'h0, tx_cnt, tx_last});
    rchk(dui_pkg::IDX_ISR_IMR, 32'ha9);
    apb(1'b1, dui_pkg::IDX_CMD, 8'h02);
    rchk(dui_pkg::IDX_ISR_IMR, 32'ha8);
    apb(1'b1, dui_pkg::IDX_DATA_A, 8'h77);
    repeat (4) @(posedge pclk);
    chk(32'h01, {24'h0, tx_cnt});
    rx(8'h41);
    rchk(dui_pkg::IDX_MASKED_IRQ_STATUS, 32'h02);
    rchk(dui_pkg::IDX_DATA_A, 32'h41);
    rchk(dui_pkg::IDX_MASKED_IRQ_STATUS, 32'h00);
    apb(1'b1, dui_pkg::IDX_MODE1_A, 8'h40);
    rx(8'h01);
    rx(8'h02);
    rchk(dui_pkg::IDX_MASKED_IRQ_STATUS, 32'h00);
    rx(8'h03);
    rx(8'h04);
    rchk(dui_pkg::IDX_MASKED_IRQ_STATUS, 32'h02);
    rchk(dui_pkg::IDX_DATA_A, 32'h01);
    repeat (3) @(posedge pclk);
    rchk(dui_pkg::IDX_MASKED_IRQ_STATUS, 32'h02);
    for (i = 2; i <= 4; i++) rchk(dui_pkg::IDX_DATA_A, 32'(i));
    rchk(dui_pkg::IDX_MASKED_IRQ_STATUS, 32'h00);
    // A direct-interrupt host never acks; forcing one here proves the bus stays quiet
    apb(1'b1, dui_pkg::IDX_ISR_IMR, 8'hff);
    ack_en <= 1'b1;
    repeat (6) @(posedge pclk);
    chk(32'h1, {30'h0, vec_oe, prio_out});
    apb(1'b1, dui_pkg::IDX_CMD, 8'h03);
    repeat (6) @(posedge pclk);
    chk(32'h25a, {22'h0, vec_oe, prio_out, vec_data});
    prio_in <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(32'h0, {30'h0, vec_oe, prio_out});
    apb(1'b0, 4'h4, 8'h00);
    chk(32'h1, {31'h0, rd_err});
    test_done();
  end
endmodule
`default_nettype wire
